// File: pkg/hbu_pkg.sv
// Shared constants and types for the host bus unit.
package hbu_pkg;

  // Width of the pin vector passed through the two-flop synchroniser.
  localparam int HBU_SYNC_W = 63;

  // Width of the base address compared against address bits 15 to 4.
  localparam int HBU_BASE_W = 12;

  // Word index presented to the core for a data port (central decode) access.
  localparam logic [1:0] HBU_DATA_PORT_IDX = 2'h2;

  // All four byte lanes active.
  localparam logic [3:0] HBU_ALL_LANES = 4'hF;

  // Reset values of the latched address path and the data outputs.
  localparam logic [15:1] HBU_ADDR_RST = 15'h0000;
  localparam logic [3:0] HBU_LANE_N_RST = 4'hF;
  localparam logic [31:0] HBU_DATA_RST = 32'h00000000;
  localparam logic [1:0] HBU_IDX_RST = 2'h0;

  // Bus handshake states.
  typedef enum logic [2:0] {
    HBU_IDLE = 3'b000,
    HBU_AREAD = 3'b001,
    HBU_AHOLD = 3'b010,
    HBU_VFETCH = 3'b011,
    HBU_VHOLD = 3'b100,
    HBU_BURST = 3'b101,
    HBU_BFETCH = 3'b110
  } hbu_state_t;

endpackage

// File: hw/hbu_sync.sv
// Two-flop synchroniser bank for pins arriving from outside the clock domain.
module hbu_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // One independent two-stage chain per bit; the first stage feeds only the second.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          meta_q <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          meta_q <= i_async[g];
          o_sync[g] <= meta_q;
        end
      end
    end
  endgenerate

endmodule

// File: hw/hbu_host_bus_unit.sv
// Host bus unit: asynchronous, single-cycle synchronous and burst host access to 16 I/O locations.
module hbu_host_bus_unit (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_bus_clk,
  input wire logic i_address_strobe_n,
  input wire logic i_address_qualifier,
  input wire logic [15:1] i_addr,
  input wire logic [3:0] i_lane_enable_n,
  input wire logic i_data_port_select_n,
  input wire logic i_async_read_strobe_n,
  input wire logic i_async_write_strobe_n,
  input wire logic i_cycle_qualifier_n,
  input wire logic i_sync_write_read,
  input wire logic i_host_ready_return_n,
  input wire logic i_sync_mode_select,
  input wire logic i_bus_8bit,
  input wire logic i_bus_32bit,
  input wire logic [31:0] i_data,
  output logic [31:0] o_data,
  output logic o_data_oe,
  output logic o_local_select_out_n,
  output logic o_async_wait_n,
  output logic o_device_ready_n,
  input wire logic [hbu_pkg::HBU_BASE_W-1:0] i_base_addr,
  input wire logic [31:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output logic [1:0] o_reg_addr,
  output logic [3:0] o_reg_lanes,
  output logic [31:0] o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic o_reg_data_port
);
  import hbu_pkg::*;

  // Synchronised copies of the host pins carry the _s suffix.
  logic [HBU_SYNC_W-1:0] sync_s;
  logic bclk_s, ads_n_s, aen_s, dcs_n_s, rd_n_s, wr_n_s, cyc_n_s, swr_s, rtn_n_s, mode_s, b8_s, b32_s;
  logic ads_s, dcs_s, rd_s, wr_s, cyc_s, rtn_s;
  logic [15:1] a_s;
  logic [3:0] be_n_s;
  logic [31:0] data_s;
  logic bclk_prev_q, rd_prev_q, wr_prev_q;
  logic [15:1] lat_a_q;
  logic lat_aen_q;
  logic [3:0] lat_be_n_q;
  logic dport, target, hit, swap, be1_n;
  logic [3:0] lanes;
  logic [1:0] idx;
  logic bclk_rise, rd_lead, rd_trail, wr_trail;
  logic a_rd, a_wr, v_start, v_wr, b_beat, b_rd, b_wr, issue_rd, issue_wr;
  logic vwr_q, swap_q;
  logic [31:0] rd_bus;
  hbu_state_t state_q;

  // Every host pin and strap crosses into the core clock through two flops.
  // Active-low pins other than the lane enables are inverted before the bank, so a cleared flop reads as idle.
  // Without this a strobe would seem to fall and rise just after reset and could start a false access.
  hbu_sync #(
    .WIDTH(HBU_SYNC_W)
  ) u_sync (
    .i_clk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_async({i_bus_clk, ~i_address_strobe_n, i_address_qualifier, i_addr, i_lane_enable_n,
              ~i_data_port_select_n, ~i_async_read_strobe_n, ~i_async_write_strobe_n,
              ~i_cycle_qualifier_n, i_sync_write_read, ~i_host_ready_return_n, i_sync_mode_select,
              i_bus_8bit, i_bus_32bit, i_data}),
    .o_sync(sync_s)
  );

  // Unpack the synchronised vector in the same order it was packed.
  assign {bclk_s, ads_s, aen_s, a_s, be_n_s, dcs_s, rd_s, wr_s, cyc_s, swr_s,
          rtn_s, mode_s, b8_s, b32_s, data_s} = sync_s;

  // Back to the pin polarity for the logic below.
  assign {ads_n_s, dcs_n_s, rd_n_s, wr_n_s, cyc_n_s, rtn_n_s} = ~{ads_s, dcs_s, rd_s, wr_s, cyc_s, rtn_s};

  // Previous samples for edge detection on the already synchronised strobes.
  // The bus clock is only a sampled level; its rise becomes a one-cycle enable for the handshakes.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bclk_prev_q <= 1'b0;
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else begin
      bclk_prev_q <= bclk_s;
      rd_prev_q <= rd_n_s;
      wr_prev_q <= wr_n_s;
    end
  end

  assign bclk_rise = bclk_s & ~bclk_prev_q;
  assign rd_lead = rd_prev_q & ~rd_n_s;
  assign rd_trail = ~rd_prev_q & rd_n_s;
  assign wr_trail = ~wr_prev_q & wr_n_s;

  // Address latch follows the pins while the strobe is low and freezes on its rise.
  // A host that ties the strobe low therefore sees a permanently open latch.
  // The reset values decode as a miss, so nothing is selected before the first address arrives.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lat_a_q <= HBU_ADDR_RST;
      lat_aen_q <= 1'b1;
      lat_be_n_q <= HBU_LANE_N_RST;
    end else if (!ads_n_s) begin
      lat_a_q <= a_s;
      lat_aen_q <= aen_s;
      lat_be_n_q <= be_n_s;
    end
  end

  // Central decode exists only in the 32-bit build and suppresses the local decoder.
  assign dport = b32_s & ~dcs_n_s;
  assign target = ~dport & ~lat_aen_q & (lat_a_q[15:4] == i_base_addr);
  assign hit = dport | target;
  assign idx = dport ? HBU_DATA_PORT_IDX : lat_a_q[3:2];

  // Lane decode. Narrow builds carry the upper word on the low lanes, so the word is swapped.
  // Bytes are never swapped; the board wiring places each byte on its own lane.
  // In the 8-bit build lane 0 acts as the byte address bit and lane 1 follows it inverted.
  always_comb begin
    swap = 1'b0;
    be1_n = b8_s ? ~lat_be_n_q[0] : lat_be_n_q[1];
    if (dport) begin
      lanes = HBU_ALL_LANES;
    end else if (b32_s) begin
      lanes = ~lat_be_n_q;
    end else begin
      swap = lat_a_q[1];
      lanes = swap ? {~be1_n, ~lat_be_n_q[0], 2'b00} : {2'b00, ~be1_n, ~lat_be_n_q[0]};
    end
  end

  // Request generation per access family; the host keeps the other family idle.
  // Burst beats are refused while the host holds ready return low, which is its wait state.
  assign a_rd = (state_q == HBU_IDLE) & rd_lead & hit;
  assign a_wr = (state_q == HBU_IDLE) & wr_trail & hit;
  assign v_start = (state_q == HBU_IDLE) & ~mode_s & bclk_rise & ~cyc_n_s & target
                   & rd_n_s & wr_n_s;
  assign v_wr = (state_q == HBU_VFETCH) & vwr_q & bclk_rise;
  assign b_beat = ((state_q == HBU_IDLE) | (state_q == HBU_BURST)) & mode_s & dport & bclk_rise
                  & rtn_n_s & (~swr_s | ~cyc_n_s);
  assign b_rd = b_beat & ~swr_s;
  assign b_wr = b_beat & swr_s;
  assign issue_rd = a_rd | (v_start & ~swr_s) | b_rd;
  assign issue_wr = a_wr | v_wr | b_wr;
  assign rd_bus = swap_q ? {i_reg_rdata[15:0], i_reg_rdata[31:16]} : i_reg_rdata;

  // Core request port: one-cycle strobes with address, lanes and write data alongside.
  // The swap is frozen with each strobe so the read answer uses the swap of its own request.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rd <= 1'b0;
      o_reg_wr <= 1'b0;
      o_reg_addr <= HBU_IDX_RST;
      o_reg_lanes <= 4'h0;
      o_reg_wdata <= HBU_DATA_RST;
      o_reg_data_port <= 1'b0;
      swap_q <= 1'b0;
    end else begin
      o_reg_rd <= issue_rd;
      o_reg_wr <= issue_wr;
      if (issue_rd || issue_wr) begin
        o_reg_addr <= idx;
        o_reg_lanes <= lanes;
        o_reg_data_port <= dport;
        swap_q <= swap;
        o_reg_wdata <= swap ? {data_s[15:0], data_s[31:16]} : data_s;
      end
    end
  end

  // Local select is registered so the output comes from a flop, one core cycle behind the latched address.
  // Data port accesses never assert it, since central decode bypasses the local decoder.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_local_select_out_n <= 1'b1;
    end else begin
      o_local_select_out_n <= ~target;
    end
  end

  // Bus handshake machine: waits, ready, and the read data drive.
  // Asynchronous reads win over a synchronous start, which the host must never overlap anyway.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= HBU_IDLE;
      vwr_q <= 1'b0;
      o_data <= HBU_DATA_RST;
      o_data_oe <= 1'b0;
      o_async_wait_n <= 1'b1;
      o_device_ready_n <= 1'b1;
    end else begin
      unique case (state_q)
        HBU_IDLE: begin
          if (a_rd) begin
            o_async_wait_n <= 1'b0;
            state_q <= HBU_AREAD;
          end else if (v_start) begin
            vwr_q <= swr_s;
            state_q <= HBU_VFETCH;
          end else if (b_rd) begin
            o_device_ready_n <= 1'b0;
            state_q <= HBU_BFETCH;
          end else if (b_wr) begin
            state_q <= HBU_BURST;
          end
        end
        HBU_AREAD: begin
          // A strobe that rises before the core answers aborts the read; a late answer is dropped.
          if (rd_n_s) begin
            o_async_wait_n <= 1'b1;
            state_q <= HBU_IDLE;
          end else if (i_reg_rvalid) begin
            o_data <= rd_bus;
            o_data_oe <= 1'b1;
            o_async_wait_n <= 1'b1;
            state_q <= HBU_AHOLD;
          end
        end
        HBU_AHOLD: begin
          // The host samples on the strobe rise, so the bus is released only after it.
          if (rd_trail) begin
            o_data_oe <= 1'b0;
            state_q <= HBU_IDLE;
          end
        end
        HBU_VFETCH: begin
          // A write waits for the next bus clock rise, by which time the host data has settled.
          if (v_wr) begin
            o_device_ready_n <= 1'b0;
            state_q <= HBU_VHOLD;
          end else if (!vwr_q && i_reg_rvalid) begin
            o_data <= rd_bus;
            o_data_oe <= 1'b1;
            o_device_ready_n <= 1'b0;
            state_q <= HBU_VHOLD;
          end
        end
        HBU_VHOLD: begin
          // Ready and read data stand until the host returns ready on a bus clock rise.
          if (bclk_rise && !rtn_n_s) begin
            o_device_ready_n <= 1'b1;
            o_data_oe <= 1'b0;
            state_q <= HBU_IDLE;
          end
        end
        HBU_BFETCH: begin
          // Device ready stays low as a wait state until the core answers.
          if (i_reg_rvalid) begin
            o_data <= rd_bus;
            o_data_oe <= 1'b1;
            o_device_ready_n <= 1'b1;
            state_q <= HBU_BURST;
          end
        end
        HBU_BURST: begin
          // Both strobes high on a bus clock rise end the burst; a write beat releases the bus.
          if (bclk_rise && swr_s && cyc_n_s) begin
            o_data_oe <= 1'b0;
            state_q <= HBU_IDLE;
          end else if (b_rd) begin
            o_device_ready_n <= 1'b0;
            state_q <= HBU_BFETCH;
          end else if (b_wr) begin
            o_data_oe <= 1'b0;
          end
        end
        default: begin
          state_q <= HBU_IDLE;
        end
      endcase
    end
  end

endmodule

// File: tb/hbu_checker.sv
// Port-level assertions for the host bus unit.
module hbu_checker
  import hbu_pkg::*;
(
  input wire logic i_mclk, i_arst_n, i_sync_mode_select, i_bus_8bit, i_bus_32bit, i_reg_rvalid,
  input wire logic [31:0] o_data,
  input wire logic o_data_oe, o_async_wait_n, o_reg_wr, o_reg_rd, o_reg_data_port,
  input wire logic [1:0] o_reg_addr,
  input wire logic [3:0] o_reg_lanes
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // Core strobes are one-cycle pulses, because a stuck strobe would repeat a transfer.
  wr_pulse_a: assert property (o_reg_wr |=> !o_reg_wr) else $error("write pulse too long");
  rd_pulse_a: assert property (o_reg_rd |=> !o_reg_rd) else $error("read pulse too long");
  drive_cause_a: assert property ($rose(o_data_oe) |-> $past(i_reg_rvalid))
    else $error("bus driven without a core answer");
  port_fields_a: assert property ((o_reg_wr || o_reg_rd) && o_reg_data_port
    |-> o_reg_lanes == HBU_ALL_LANES && o_reg_addr == HBU_DATA_PORT_IDX) else $error("data port fields wrong");
  port_build_a: assert property ((o_reg_wr || o_reg_rd) && o_reg_data_port |-> i_bus_32bit)
    else $error("data port used outside 32-bit build");
  wait_read_a: assert property ($fell(o_async_wait_n) |-> o_reg_rd)
    else $error("wait without a read");
  read_hold_a: assert property (o_data_oe && $past(o_data_oe) && !i_sync_mode_select |-> $stable(o_data))
    else $error("read data changed while held");
  byte_lane_a: assert property ((o_reg_wr || o_reg_rd) && i_bus_8bit && !o_reg_data_port
    |-> (^o_reg_lanes[1:0]) || (^o_reg_lanes[3:2])) else $error("8-bit lane pair not one-hot");
  // Main scenarios reached.
  cover property (o_reg_rd && o_reg_data_port);
  cover property ($fell(o_async_wait_n));
  cover property (o_reg_wr && i_sync_mode_select);
endmodule

// File: tb/hbu_core_model.sv
// Register core behind the unit: four words, answering reads after one or three cycles.
module hbu_core_model (
  input wire logic i_mclk,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [1:0] i_addr,
  input wire logic [3:0] i_lanes,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [4] = '{default: 32'h0};
  logic [1:0] idx = 2'h0;
  int cnt = 0;
  bit slow = 0;
  initial o_rvalid = 1'b0;
  initial o_rdata = 32'h0;
  // Read data toggles between answers so a stale value is never mistaken for a fresh one.
  always @(posedge i_mclk) begin
    o_rvalid <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_wr === 1'b1)
      for (int b = 0; b < 4; b++) if (i_lanes[b]) mem[i_addr][8*b+:8] <= i_wdata[8*b+:8];
    if (i_rd === 1'b1) begin
      idx <= i_addr;
      cnt <= slow ? 3 : 1;
      slow <= !slow;
    end else if (cnt == 1) begin
      o_rvalid <= 1'b1;
      o_rdata <= mem[idx];
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule

// File: tb/hbu_host_bus_unit_test.sv
// Self-checking bench for the host bus unit with a behavioural register model.
module hbu_host_bus_unit_test;
  import hbu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] BASE = 12'hA5C;
  logic mclk = 0, arst_n = 0, bclk = 0, as_n = 0, aq = 0, dp_n = 1, rd_n = 1, wr_n = 1;
  logic cq_n = 1, sync_write_read = 0, ret_n = 1, msel = 0, b8 = 0, b32 = 1, oe, aw_n, rdy_n, rv, wr, rd, dport, ls_n;
  logic [15:1] addr = 15'h0000;
  logic [3:0] le_n = 4'hF, rl, last_l = 4'h0;
  logic [31:0] din = 32'h0, dout, rdat, wdat, d;
  logic [1:0] ra, ix;
  logic [31:0] exp_mem [4] = '{default: 32'h0};
  logic [3:0] lane_codes [6] = '{4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7};
  int n_fail = 0, total_checks = 0, seed = 17573, nrd = 0, nwr = 0, n0;
  hbu_host_bus_unit i_hbu_host_bus_unit (.i_mclk(mclk), .i_arst_n(arst_n), .i_bus_clk(bclk),
    .i_address_strobe_n(as_n), .i_address_qualifier(aq), .i_addr(addr), .i_lane_enable_n(le_n),
    .i_data_port_select_n(dp_n), .i_async_read_strobe_n(rd_n), .i_async_write_strobe_n(wr_n),
    .i_cycle_qualifier_n(cq_n), .i_sync_write_read(sync_write_read), .i_host_ready_return_n(ret_n),
    .i_sync_mode_select(msel), .i_bus_8bit(b8), .i_bus_32bit(b32), .i_data(din), .o_data(dout),
    .o_data_oe(oe), .o_local_select_out_n(ls_n), .o_async_wait_n(aw_n), .o_device_ready_n(rdy_n),
    .i_base_addr(BASE), .i_reg_rdata(rdat), .i_reg_rvalid(rv), .o_reg_addr(ra), .o_reg_lanes(rl),
    .o_reg_wdata(wdat), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_data_port(dport));
  hbu_core_model i_hbu_core_model (.i_mclk(mclk), .i_rd(rd), .i_wr(wr), .i_addr(ra), .i_lanes(rl),
    .i_wdata(wdat), .o_rdata(rdat), .o_rvalid(rv));
  initial forever #25 mclk = ~mclk;
  // Core strobe counts let burst checks see stalls without peeking inside.
  always @(posedge mclk) begin
    nrd += (rd === 1'b1);
    nwr += (wr === 1'b1);
    if (wr === 1'b1) last_l <= rl;
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One 400 ns bus clock period, high half first.
  task automatic bedge();
    bclk = 1;
    ticks(4);
    bclk = 0;
    ticks(4);
  endtask
  task automatic put(input logic [1:0] b, input logic [3:0] l, input logic [31:0] v);
    for (int k = 0; k < 4; k++) if (l[k]) exp_mem[b][8*k+:8] = v[8*k+:8];
  endtask
  // Asynchronous single access with the latch held open.
  task automatic acc(input bit w, input logic [11:0] hi, input logic [1:0] i, input logic q, input bit ds,
      input logic [3:0] l_n, input logic [31:0] v, input bit hit, input bit a1 = 1'b0);
    bit waited;
    bit sw;
    logic [1:0] t;
    logic [3:0] el;
    waited = 0;
    t = ds ? HBU_DATA_PORT_IDX : i;
    // Expected lanes and word placement, worked out from the strap levels.
    sw = a1 && !b32 && !ds;
    el = ds ? HBU_ALL_LANES : ~l_n;
    if (!ds && b8) el[1] = l_n[0];
    if (!ds && !b32) el = a1 ? {el[1:0], 2'b00} : {2'b00, el[1:0]};
    addr = {hi, i, a1};
    aq = q;
    dp_n = !ds;
    le_n = l_n;
    din = v;
    ticks(1);
    if (w) begin
      wr_n = 0;
      ticks(4);
      wr_n = 1;
      ticks(6);
      if (hit) put(t, el, sw ? {v[15:0], v[31:16]} : v);
    end else begin
      rd_n = 0;
      for (int k = 0; k < 40 && oe !== 1'b1; k++) begin
        ticks(1);
        if (aw_n === 1'b0) waited = 1;
      end
      chk("async drive", 32'(hit), 32'(oe));
      chk("async wait", 32'(hit), 32'(waited));
      if (hit) chk("async data", sw ? {exp_mem[t][15:0], exp_mem[t][31:16]} : exp_mem[t], dout);
      rd_n = 1;
      ticks(5);
      chk("async release", 0, 32'(oe));
    end
    chk("async wait idle", 1, 32'(aw_n));
    chk("local select", 32'(!(hit && !ds)), 32'(ls_n));
    dp_n = 1;
    ticks(1);
  endtask
  task automatic vl(input bit w, input logic [1:0] i, input logic [31:0] v);
    int t;
    addr = {BASE, i, 1'b0};
    aq = 0;
    le_n = 4'h0;
    din = v;
    bedge();
    as_n = 1;
    addr = ~addr;
    aq = 1;
    cq_n = 0;
    sync_write_read = w;
    ticks(1);
    bedge();
    cq_n = 1;
    for (t = 0; t < 10 && rdy_n !== 1'b0; t++) bedge();
    chk("vl ready", 0, 32'(rdy_n));
    if (w) put(i, HBU_ALL_LANES, v);
    else chk("vl data", exp_mem[i], dout);
    ret_n = 0;
    bedge();
    ret_n = 1;
    ticks(3);
    chk("vl ready off", 1, 32'(rdy_n));
    as_n = 0;
    aq = 0;
  endtask
  // Four burst bus clocks, the second stalled by the host, so three beats reach the core.
  task automatic burst(input bit w, input logic [31:0] v);
    msel = 1;
    dp_n = 0;
    le_n = 4'h5;
    sync_write_read = 1;
    ticks(4);
    n0 = w ? nwr : nrd;
    for (int k = 0; k < 4; k++) begin
      din = v + 32'(k);
      cq_n = !w;
      sync_write_read = w;
      ret_n = (k != 1);
      bedge();
      ticks(4);
      if (!w && k != 1) chk("burst data", exp_mem[HBU_DATA_PORT_IDX], dout);
    end
    cq_n = 1;
    sync_write_read = 1;
    ret_n = 1;
    bedge();
    chk("burst beats", 3, 32'((w ? nwr : nrd) - n0));
    if (w) put(HBU_DATA_PORT_IDX, HBU_ALL_LANES, v + 32'h3);
    chk("burst end", 0, 32'(oe));
    msel = 0;
    sync_write_read = 0;
    dp_n = 1;
    ticks(4);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #3000000;
    n_fail++;
    complete_run();
  end
  initial begin
    ticks(12);
    arst_n = 1;
    ticks(4);
    foreach (exp_mem[k]) begin
      ix = 2'(k);
      acc(1, BASE, ix, 0, 0, 4'h0, $random(seed), 1);
      acc(0, BASE, ix, 0, 0, 4'h0, 0, 1);
    end
    foreach (lane_codes[k]) begin
      acc(1, BASE, 1, 0, 0, lane_codes[k], $random(seed), 1);
      acc(0, BASE, 1, 0, 0, 4'h0, 0, 1);
    end
    acc(0, ~BASE, 1, 0, 0, 4'h0, 0, 0);
    acc(1, BASE, 1, 1, 0, 4'h0, 32'h5A5A5A5A, 0);
    acc(0, BASE, 1, 0, 0, 4'h0, 0, 1);
    d = $random(seed);
    acc(1, ~BASE, 0, 1, 1, 4'hE, d, 1);
    acc(0, ~BASE, 0, 1, 1, 4'h7, 0, 1);
    vl(1, 3, $random(seed));
    vl(0, 3, 0);
    burst(1, $random(seed));
    burst(0, 0);
    b32 = 0;
    b8 = 1;
    ticks(4);
    acc(1, BASE, 0, 0, 0, 4'hE, $random(seed), 1);
    chk("byte lanes", 32'h1, 32'(last_l));
    acc(1, BASE, 0, 0, 0, 4'hF, $random(seed), 1);
    chk("odd byte lane", 32'h2, 32'(last_l));
    acc(0, BASE, 0, 0, 0, 4'hF, 0, 1);
    b8 = 0;
    ticks(4);
    acc(1, BASE, 2, 0, 0, 4'hC, $random(seed), 1, 1);
    chk("upper word lanes", 32'hC, 32'(last_l));
    acc(0, BASE, 2, 0, 0, 4'h0, 0, 1, 1);
    acc(0, BASE, 2, 0, 0, 4'h0, 0, 1);
    complete_run();
  end
endmodule
bind hbu_host_bus_unit hbu_checker i_hbu_checker (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
  .i_sync_mode_select(i_sync_mode_select), .i_bus_8bit(i_bus_8bit), .i_bus_32bit(i_bus_32bit),
  .i_reg_rvalid(i_reg_rvalid), .o_data(o_data), .o_data_oe(o_data_oe), .o_async_wait_n(o_async_wait_n),
  .o_reg_wr(o_reg_wr), .o_reg_rd(o_reg_rd), .o_reg_data_port(o_reg_data_port), .o_reg_addr(o_reg_addr),
  .o_reg_lanes(o_reg_lanes));
